// File: emr_core.v
// The Avalon-MM interface to the registers and the address map were left to the implementer.
`include "emr_consts.vh"

module emr_core #(
  parameter DQ_W = 16,
  parameter SW   = 4
) (
  input  wire            clock,
  input  wire            rst,
  // Avalon-MM slave
  input  wire [2:0]      avs_address,
  input  wire            avs_read,
  input  wire            avs_write,
  input  wire [31:0]     avs_writedata,
  output reg  [31:0]     avs_readdata,
  output reg             avs_waitrequest,
  // Memory command pins
  input  wire            ck,
  input  wire            cke,
  input  wire            cs_n,
  input  wire            ras_n,
  input  wire            cas_n,
  input  wire            we_n,
  input  wire [2:0]      ba,
  input  wire [13:0]     addr,
  input  wire [DQ_W-1:0] dq_in,
  // Data and strobe drivers
  output reg  [DQ_W-1:0] dq_out,
  output reg             dq_oe,
  output reg             dqs_out,
  output reg             dqs_oe,
  output reg             dqs_n_out,
  output reg             dqs_n_oe,
  // Decoded controls
  output reg             dll_active,
  output reg             half_strength,
  output reg  [1:0]      die_termination,
  output reg  [2:0]      posted_command_delay,
  output reg             fast_self_refresh,
  output reg             duty_cycle_corrector,
  output reg  [7:0]      refresh_bank_mask,
  output wire [SW-1:0]   pullup_step,
  output wire [SW-1:0]   pulldown_step
);

  // ****************************************
  // Calibration states
  // ****************************************
  localparam [4:0] ST_IDLE    = 5'h01; // No calibration
  localparam [4:0] ST_DRIVE1  = 5'h02; // Drive high levels
  localparam [4:0] ST_DRIVE0  = 5'h04; // Drive low levels
  localparam [4:0] ST_ADJUST  = 5'h08; // Waiting for write
  localparam [4:0] ST_CAPTURE = 5'h10; // Taking burst code

  // ****************************************
  // Functions
  // ****************************************
  // Bank mask kept during partial array refresh
  function [7:0] partial_array_refresh_mask;
    input [2:0] sel;
    begin
      case (sel)
        3'h0:    partial_array_refresh_mask = 8'hff;
        3'h1:    partial_array_refresh_mask = 8'h0f;
        3'h2:    partial_array_refresh_mask = 8'h03;
        3'h3:    partial_array_refresh_mask = 8'h01;
        3'h4:    partial_array_refresh_mask = 8'hfc;
        3'h5:    partial_array_refresh_mask = 8'hf0;
        3'h6:    partial_array_refresh_mask = 8'hc0;
        default: partial_array_refresh_mask = 8'h80;
      endcase
    end
  endfunction

  // Burst code {T0,T1,T2,T3} to {pu_inc,pu_dec,pd_inc,pd_dec}
  function [3:0] adj_decode;
    input [3:0] t;
    begin
      case (t)
        4'h1:    adj_decode = 4'h8;
        4'h2:    adj_decode = 4'h4;
        4'h4:    adj_decode = 4'h2;
        4'h8:    adj_decode = 4'h1;
        4'h5:    adj_decode = 4'ha;
        4'h6:    adj_decode = 4'h6;
        4'h9:    adj_decode = 4'h9;
        4'ha:    adj_decode = 4'h5;
        default: adj_decode = 4'h0;
      endcase
    end
  endfunction

  // ****************************************
  // Pin synchronisers
  // ****************************************
  wire        ck_s;      // Synced link clock
  wire        cke_s;     // Synced clock enable
  wire [3:0]  ctl_s;     // Synced cs, ras, cas, we
  wire [2:0]  ba_s;      // Synced bank bits
  wire [13:0] addr_s;    // Synced address
  wire        dq0_s;     // Synced data bit zero

  emr_sync #(.W(1)) u_sync_ck (
    .clock (clock),
    .rst   (rst),
    .d     (ck),
    .q_r   (ck_s)
  );

  emr_sync #(.W(23)) u_sync_cmd (
    .clock (clock),
    .rst   (rst),
    .d     ({cke, cs_n, ras_n, cas_n, we_n, ba, addr, dq_in[0]}),
    .q_r   ({cke_s, ctl_s, ba_s, addr_s, dq0_s})
  );

  // ****************************************
  // Link edge detection and command decode
  // ****************************************
  reg  ck_d_r;           // Previous synced clock
  reg  cke_prev_r;       // Clock enable at last rising edge
  wire ck_rise;          // Rising link edge
  wire ck_edge;          // Any link edge
  wire cmd_regset;       // Register-set command
  wire cmd_sr_entry;     // Self refresh entry
  wire cmd_write;        // Write command

  assign ck_rise      = ck_s & ~ck_d_r;
  assign ck_edge      = ck_s ^ ck_d_r;
  assign cmd_regset   = ck_rise & cke_prev_r & cke_s & (ctl_s == 4'h0);
  assign cmd_sr_entry = ck_rise & cke_prev_r & ~cke_s & (ctl_s == 4'h1);
  assign cmd_write    = ck_rise & cke_s & (ctl_s == 4'h4);

  // Track link clock and clock enable
  always @(posedge clock) begin
    if (rst) begin
      ck_d_r     <= 1'b0;
      cke_prev_r <= 1'b0;
    end else begin
      ck_d_r <= ck_s;
      if (ck_rise) begin
        cke_prev_r <= cke_s;
      end
    end
  end

  // ****************************************
  // Extended registers
  // ****************************************
  reg [14:0] emr1_r;     // {ba2, addr} of register one
  reg [14:0] emr2_r;     // {ba2, addr} of register two
  reg [14:0] emr3_r;     // {ba2, addr} of register three
  reg [2:0]  written_r;  // Which registers were loaded
  reg        sr_r;       // In self refresh

  // Load on register-set command by bank bits
  always @(posedge clock) begin
    if (rst) begin
      emr1_r    <= `EMR_RST_REG;
      emr2_r    <= `EMR_RST_REG;
      emr3_r    <= `EMR_RST_REG;
      written_r <= 3'h0;
    end else if (cmd_regset) begin
      case (ba_s[1:0])
        `EMR_BA_EMR1: begin
          emr1_r       <= {ba_s[2], addr_s};
          written_r[0] <= 1'b1;
        end
        `EMR_BA_EMR2: begin
          emr2_r       <= {ba_s[2], addr_s};
          written_r[1] <= 1'b1;
        end
        `EMR_BA_EMR3: begin
          emr3_r       <= {ba_s[2], addr_s};
          written_r[2] <= 1'b1;
        end
        default: begin
          // Base mode register lives elsewhere
        end
      endcase
    end
  end

  // Self refresh on entry, off when clock enable rises
  always @(posedge clock) begin
    if (rst) begin
      sr_r <= 1'b0;
    end else if (cmd_sr_entry) begin
      sr_r <= 1'b1;
    end else if (ck_rise && cke_s) begin
      sr_r <= 1'b0;
    end
  end

  // ****************************************
  // Calibration engine
  // ****************************************
  reg  [4:0] cal_st_r;   // Calibration state
  reg  [4:0] cal_nxt;    // Next state
  reg  [2:0] beat_r;     // Burst beats taken
  reg  [3:0] code_r;     // Burst code, T0 first
  reg        def_load_r; // Load default strength
  reg  [3:0] adj_r;      // Step pulses
  wire [2:0] cal_cmd;    // Calibration field of register one

  assign cal_cmd = addr_s[`EMR_F1_CAL_HI:`EMR_F1_CAL_LO];

  // Next state from calibration field and burst
  always @* begin
    cal_nxt = cal_st_r;
    if (cmd_regset && (ba_s[1:0] == `EMR_BA_EMR1)) begin
      case (cal_cmd)
        `EMR_CAL_EXIT:    cal_nxt = ST_IDLE;
        `EMR_CAL_DRIVE1:  cal_nxt = ST_DRIVE1;
        `EMR_CAL_DRIVE0:  cal_nxt = ST_DRIVE0;
        `EMR_CAL_ADJUST:  cal_nxt = ST_ADJUST;
        `EMR_CAL_DEFAULT: cal_nxt = ST_IDLE;
        default:          cal_nxt = cal_st_r;
      endcase
    end else begin
      case (cal_st_r)
        ST_ADJUST: begin
          if (cmd_write) begin
            cal_nxt = ST_CAPTURE;
          end
        end
        ST_CAPTURE: begin
          if (ck_edge && (beat_r == `EMR_ADJ_BEATS - 3'h1)) begin
            cal_nxt = ST_ADJUST;
          end
        end
        ST_IDLE, ST_DRIVE1, ST_DRIVE0: begin
          cal_nxt = cal_st_r;
        end
        default: cal_nxt = ST_IDLE;
      endcase
    end
  end

  // State, burst capture and step pulses
  always @(posedge clock) begin
    if (rst) begin
      cal_st_r   <= ST_IDLE;
      beat_r     <= 3'h0;
      code_r     <= 4'h0;
      def_load_r <= 1'b0;
      adj_r      <= 4'h0;
    end else begin
      cal_st_r   <= cal_nxt;
      def_load_r <= cmd_regset && (ba_s[1:0] == `EMR_BA_EMR1) &&
                    (cal_cmd == `EMR_CAL_DEFAULT);
      adj_r      <= 4'h0;
      if (cal_st_r != ST_CAPTURE) begin
        beat_r <= 3'h0;
      end else if (ck_edge) begin
        beat_r <= beat_r + 3'h1;
        code_r <= {code_r[2:0], dq0_s};
        if (beat_r == `EMR_ADJ_BEATS - 3'h1) begin
          adj_r <= adj_decode({code_r[2:0], dq0_s});
        end
      end
    end
  end

  // One strength pair shared by every data line
  emr_step #(.W(SW), .DEF(`EMR_STEP_DEFAULT)) u_pullup (
    .clock  (clock),
    .rst    (rst),
    .load   (def_load_r),
    .inc    (adj_r[3]),
    .dec    (adj_r[2]),
    .step_r (pullup_step)
  );

  emr_step #(.W(SW), .DEF(`EMR_STEP_DEFAULT)) u_pulldown (
    .clock  (clock),
    .rst    (rst),
    .load   (def_load_r),
    .inc    (adj_r[1]),
    .dec    (adj_r[0]),
    .step_r (pulldown_step)
  );

  // ****************************************
  // Registered outputs
  // ****************************************
  reg  [31:0] ctrl_r;    // Software control word
  wire        qoff;      // Output disable
  wire        drive_on;  // A drive mode is active
  wire        drive_hi;  // Drive high levels

  assign qoff     = emr1_r[`EMR_F1_QOFF];
  assign drive_on = (cal_st_r == ST_DRIVE1) || (cal_st_r == ST_DRIVE0);
  assign drive_hi = (cal_st_r == ST_DRIVE1);

  // Drivers and decoded controls
  always @(posedge clock) begin
    if (rst) begin
      dq_out               <= {DQ_W{1'b0}};
      dq_oe                <= 1'b0;
      dqs_out              <= 1'b0;
      dqs_oe               <= 1'b0;
      dqs_n_out            <= 1'b0;
      dqs_n_oe             <= 1'b0;
      dll_active           <= 1'b0;
      half_strength        <= 1'b0;
      die_termination      <= 2'h0;
      posted_command_delay <= 3'h0;
      fast_self_refresh    <= 1'b0;
      duty_cycle_corrector <= 1'b0;
      refresh_bank_mask    <= 8'hff;
    end else begin
      dq_out    <= {DQ_W{drive_hi}};
      dqs_out   <= drive_hi;
      dqs_n_out <= ~drive_hi;
      dq_oe     <= drive_on & ~qoff;
      dqs_oe    <= drive_on & ~qoff;
      dqs_n_oe  <= drive_on & ~qoff & ~emr1_r[`EMR_F1_STROBE_N_DIS];
      dll_active <= ~emr1_r[`EMR_F1_DLL_DIS] & ~sr_r;
      half_strength   <= emr1_r[`EMR_F1_HALF];
      die_termination <= {emr1_r[`EMR_F1_TERM_HI], emr1_r[`EMR_F1_TERM_LO]};
      posted_command_delay <= emr1_r[`EMR_F1_PCD_HI:`EMR_F1_PCD_LO];
      fast_self_refresh    <= emr2_r[`EMR_F2_FAST_SR] & ctrl_r[0];
      duty_cycle_corrector <= emr2_r[`EMR_F2_DCC];
      refresh_bank_mask    <= sr_r ? partial_array_refresh_mask(emr2_r[`EMR_F2_PARTIAL_ARRAY_REFRESH_HI:`EMR_F2_PARTIAL_ARRAY_REFRESH_LO])
                                   : 8'hff;
    end
  end

  // ****************************************
  // Avalon-MM slave
  // ****************************************
  // Waitrequest idles high, drops one cycle per access
  always @(posedge clock) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
      ctrl_r          <= `EMR_RST_CTRL;
    end else if ((avs_read || avs_write) && avs_waitrequest) begin
      avs_waitrequest <= 1'b0;
      case (avs_address)
        `EMR_IDX_EMR1:   avs_readdata <= {17'h00000, emr1_r};
        `EMR_IDX_EMR2:   avs_readdata <= {17'h00000, emr2_r};
        `EMR_IDX_EMR3:   avs_readdata <= {17'h00000, emr3_r};
        `EMR_IDX_STATUS: avs_readdata <= {12'h000, pulldown_step, pullup_step,
                                          cal_st_r, dll_active, sr_r, 2'h0,
                                          written_r};
        `EMR_IDX_CTRL:   avs_readdata <= ctrl_r;
        default:         avs_readdata <= 32'h0000_0000;
      endcase
    end else begin
      avs_waitrequest <= 1'b1;
      if (avs_write && !avs_waitrequest && (avs_address == `EMR_IDX_CTRL)) begin
        ctrl_r <= {31'h0000_0000, avs_writedata[0]};
      end
    end
  end

endmodule // emr_core

// File: emr_consts.vh
`ifndef EMR_CONSTS_VH
`define EMR_CONSTS_VH

// ****************************************
// Register map (word index, byte = 4*index)
// ****************************************
`define EMR_IDX_EMR1        3'h0
`define EMR_IDX_EMR2        3'h1
`define EMR_IDX_EMR3        3'h2
`define EMR_IDX_STATUS      3'h3
`define EMR_IDX_CTRL        3'h4

// ****************************************
// Bank select codes for register-set command
// ****************************************
`define EMR_BA_EMR1         2'h1
`define EMR_BA_EMR2         2'h2
`define EMR_BA_EMR3         2'h3

// ****************************************
// Extended register one fields
// ****************************************
`define EMR_F1_DLL_DIS      0
`define EMR_F1_HALF         1
`define EMR_F1_TERM_LO      2
`define EMR_F1_PCD_LO       3
`define EMR_F1_PCD_HI       5
`define EMR_F1_TERM_HI      6
`define EMR_F1_CAL_LO       7
`define EMR_F1_CAL_HI       9
`define EMR_F1_STROBE_N_DIS 10
`define EMR_F1_QOFF         12

// ****************************************
// Extended register two fields
// ****************************************
`define EMR_F2_PARTIAL_ARRAY_REFRESH_LO      0
`define EMR_F2_PARTIAL_ARRAY_REFRESH_HI      2
`define EMR_F2_DCC          3
`define EMR_F2_FAST_SR      7

// ****************************************
// Calibration commands and adjust burst beats
// ****************************************
`define EMR_CAL_EXIT        3'h0
`define EMR_CAL_DRIVE1      3'h1
`define EMR_CAL_DRIVE0      3'h2
`define EMR_CAL_ADJUST      3'h4
`define EMR_CAL_DEFAULT     3'h7
`define EMR_ADJ_BEATS       3'h4

// ****************************************
// Reset values
// ****************************************
`define EMR_RST_REG         15'h0000
`define EMR_RST_CTRL        32'h0000_0001
`define EMR_STEP_DEFAULT    4'h8

`endif

// File: emr_sync.v
// ****************************************
// Two-flop synchroniser
// ****************************************
module emr_sync #(
  parameter W = 1
) (
  input  wire         clock,
  input  wire         rst,
  input  wire [W-1:0] d,
  output reg  [W-1:0] q_r
);

  reg [W-1:0] meta_r; // First stage, read only by second

  // Two stages, cleared by reset
  always @(posedge clock) begin
    if (rst) begin
      meta_r <= {W{1'b0}};
      q_r    <= {W{1'b0}};
    end else begin
      meta_r <= d;
      q_r    <= meta_r;
    end
  end

endmodule // emr_sync

// File: emr_step.v
// ****************************************
// Saturating driver strength step
// ****************************************
module emr_step #(
  parameter       W   = 4,
  parameter [W-1:0] DEF = 4'h8
) (
  input  wire         clock,
  input  wire         rst,
  input  wire         load,
  input  wire         inc,
  input  wire         dec,
  output reg  [W-1:0] step_r
);

  localparam [W-1:0] TOP = {W{1'b1}}; // Highest step

  // Load default, or step with saturation
  always @(posedge clock) begin
    if (rst) begin
      step_r <= DEF;
    end else if (load) begin
      step_r <= DEF;
    end else if (inc && (step_r != TOP)) begin
      step_r <= step_r + {{(W-1){1'b0}}, 1'b1};
    end else if (dec && (step_r != {W{1'b0}})) begin
      step_r <= step_r - {{(W-1){1'b0}}, 1'b1};
    end
  end

endmodule // emr_step

// File: emr_core_chk.sv
// ****************************************
// Port checker for the register block
// ****************************************
module emr_core_chk #(
  parameter DQ_W = 16,
  parameter SW   = 4
) (
  input logic            clock,
  input logic            rst,
  input logic            avs_read,
  input logic            avs_write,
  input logic            avs_waitrequest,
  input logic [DQ_W-1:0] dq_out,
  input logic            dq_oe,
  input logic            dqs_out,
  input logic            dqs_oe,
  input logic            dqs_n_out,
  input logic            dqs_n_oe,
  input logic [7:0]      refresh_bank_mask,
  input logic [SW-1:0]   pullup_step,
  input logic [SW-1:0]   pulldown_step
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  // Bus answers after exactly one wait cycle
  a_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");
  a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("wait low for more than one cycle");
  // Drive levels and strobe pairing
  a_dq_uniform: assert property (dq_oe |-> dq_out == {DQ_W{dq_out[0]}})
    else $error("data lines differ while driven");
  a_strobe_level: assert property (dqs_oe |-> dq_oe && dqs_out == dq_out[0])
    else $error("strobe level differs from data");
  a_strobe_pair: assert property (dqs_n_oe |-> dqs_oe && dqs_n_out == !dqs_out)
    else $error("complement strobe not inverse");
  a_oe_group: assert property (dq_oe == dqs_oe)
    else $error("data and strobe enables differ");
  a_drive_hold: assert property ($rose(dq_oe) |=> (dq_oe && $stable(dq_out)) [*4])
    else $error("drive level not held");
  // Steps move by one, or reload the default
  a_pu_sat: assert property (pullup_step != $past(pullup_step) |->
    pullup_step == $past(pullup_step) + 1 || pullup_step == $past(pullup_step) - 1 ||
    pullup_step == 4'h8) else $error("pull-up step jumped");
  a_pd_sat: assert property (pulldown_step != $past(pulldown_step) |->
    pulldown_step == $past(pulldown_step) + 1 || pulldown_step == $past(pulldown_step) - 1 ||
    pulldown_step == 4'h8) else $error("pull-down step jumped");
  a_steps_idle: assert property (dq_oe |-> $stable(pullup_step) && $stable(pulldown_step))
    else $error("step moved during drive");
  a_mask_code: assert property (refresh_bank_mask inside {8'hff, 8'h0f, 8'h03, 8'h01,
    8'hfc, 8'hf0, 8'hc0, 8'h80}) else $error("bad refresh mask");
endmodule // emr_core_chk

// File: emr_ctl_model.sv
// ****************************************
// Memory controller model on the link
// ****************************************
module emr_ctl_model #(
  parameter DQ_W = 16
) (
  output logic            ck,
  output logic            cke,
  output logic            cs_n,
  output logic            ras_n,
  output logic            cas_n,
  output logic            we_n,
  output logic [2:0]      ba,
  output logic [13:0]     addr,
  output logic [DQ_W-1:0] dq
);
  timeunit 1ns;
  timeprecision 100ps;
  // Free-running link clock, odd phase
  initial begin
    {cke, cs_n, ras_n, cas_n, we_n} = 5'h1f;
    ba = 3'h0;
    addr = 14'h0;
    dq = '0;
    ck = 1'b0;
    #37;
    forever #100 ck = ~ck;
  end
  // One command at a rising link edge, then deselect
  task automatic cmd(input logic c, r, ca, w, e, input logic [2:0] b, input logic [13:0] a);
    @(negedge ck);
    cke = e;
    {cs_n, ras_n, cas_n, we_n} = {c, r, ca, w};
    ba = b;
    addr = a;
    @(posedge ck);
    #75;
    cs_n = 1'b1;
    ba = ~ba;
    addr = ~addr;
  endtask
  // Write command and a four-beat code on all data lines
  task automatic burst(input logic [3:0] c);
    dq = {DQ_W{c[3]}};
    cmd(1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 3'h0, 14'h0);
    for (int i = 2; i >= 0; i--) begin
      @(ck);
      #50;
      dq = {DQ_W{c[i]}};
    end
    @(ck);
    #50;
    dq = ~dq;
  endtask
endmodule // emr_ctl_model

// File: emr_core_bench.sv
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin err_total++; \
  $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end

module emr_core_bench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam DQ_W = 16;
  localparam SW   = 4;
  // ****************************************
  // Signals
  // ****************************************
  logic            clock = 0, rst = 1, avs_read = 0, avs_write = 0;
  logic [2:0]      avs_address = 0;
  logic [31:0]     avs_writedata = 0, avs_readdata, e_m;
  wire             avs_waitrequest, ck, cke, cs_n, ras_n, cas_n, we_n;
  wire  [2:0]      ba;
  wire  [13:0]     addr;
  wire  [DQ_W-1:0] dq_in, dq_out;
  wire             dq_oe, dqs_out, dqs_oe, dqs_n_out, dqs_n_oe, dll_active, half_strength;
  wire  [1:0]      die_termination;
  wire  [2:0]      posted_command_delay;
  wire             fast_self_refresh, duty_cycle_corrector;
  wire  [7:0]      refresh_bank_mask;
  wire  [SW-1:0]   pullup_step, pulldown_step;
  int              err_total = 0, n_tests = 0;
  logic [31:0]     exp_q[$];          // Expected read data
  logic [31:0]     rnd = 32'hbd8cc0d6; // Random state
  logic [3:0]      pu = 4'h8, pd = 4'h8;
  logic [2:0]      flg = 3'h0;         // Written-register flags
  logic [13:0]     e1;                 // Register one base value

  emr_core #(.DQ_W(DQ_W), .SW(SW)) u_dut (.clock, .rst, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .ck, .cke, .cs_n, .ras_n, .cas_n, .we_n,
    .ba, .addr, .dq_in, .dq_out, .dq_oe, .dqs_out, .dqs_oe, .dqs_n_out, .dqs_n_oe, .dll_active,
    .half_strength, .die_termination, .posted_command_delay, .fast_self_refresh,
    .duty_cycle_corrector, .refresh_bank_mask, .pullup_step, .pulldown_step);
  emr_ctl_model #(.DQ_W(DQ_W)) u_ctl (.ck, .cke, .cs_n, .ras_n, .cas_n, .we_n, .ba, .addr,
    .dq(dq_in));

  initial forever #12.5 clock = ~clock;
  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] st(input logic [4:0] cal);
    st = {12'h0, pd, pu, cal, 1'b1, 1'b0, 2'b00, flg};
  endfunction
  task automatic results;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // One bus access, held until wait seen low
  task automatic av(input logic wr, input logic [2:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    do begin @(posedge clock); n++; end while (avs_waitrequest !== 1'b0 && n < 20);
    if (n >= 20) begin err_total++; $display("CHECK FAILED wait exp 0 got 1"); end
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rd(input logic [2:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    av(1'b0, a, 32'h0);
  endtask
  // Register-set command, then settle
  task automatic lk(input logic [2:0] b, input logic [13:0] a);
    u_ctl.cmd(1'b0, 1'b0, 1'b0, 1'b0, 1'b1, b, a);
    repeat (8) @(posedge clock);
  endtask
  // Adjust with one code, exit, update expected steps
  task automatic adj(input logic [3:0] c);
    lk(3'h1, e1 | 14'h0200);
    u_ctl.burst(c);
    repeat (10) @(posedge clock);
    lk(3'h1, e1);
    if (c inside {4'h0, 4'h1, 4'h2, 4'h4, 4'h8, 4'h5, 4'h6, 4'h9, 4'ha}) begin
      if (c[0] && pu != 4'hf) pu++;
      if (c[1] && pu != 4'h0) pu--;
      if (c[2] && pd != 4'hf) pd++;
      if (c[3] && pd != 4'h0) pd--;
    end
    rd(3'h3, st(5'h01));
    `CHK("steps", {pd, pu}, {pulldown_step, pullup_step})
  endtask
  // Read monitor takes the oldest note
  always @(posedge clock) if (avs_read && avs_waitrequest === 1'b0) begin
    e_m = exp_q.pop_front();
    `CHK("readdata", e_m, avs_readdata)
  end
  // Watchdog
  initial begin
    repeat (40000) @(posedge clock);
    err_total++;
    results();
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    rd(3'h4, 32'h1);
    rd(3'h0, 32'h0);
    rd(3'h7, 32'h0);
    av(1'b1, 3'h0, 32'hffffffff);
    rd(3'h0, 32'h0);
    $display("test regs done");
    lk(3'h2, 14'h008b);
    flg = 3'h2;
    `CHK("dcc", 1'b1, duty_cycle_corrector)
    `CHK("fast", 1'b1, fast_self_refresh)
    rd(3'h1, 32'h8b);
    av(1'b1, 3'h4, 32'h0);
    repeat (2) @(posedge clock);
    `CHK("fast", 1'b0, fast_self_refresh)
    av(1'b1, 3'h4, 32'h1);
    lk(3'h3, 14'h0);
    flg = 3'h6;
    rd(3'h3, st(5'h01));
    rnd = lfsr(rnd);
    e1 = {8'h0, rnd[2:0], 3'b110};
    lk(3'h1, e1);
    flg = 3'h7;
    `CHK("half", 1'b1, half_strength)
    `CHK("term", 2'b01, die_termination)
    `CHK("pcd", rnd[2:0], posted_command_delay)
    rd(3'h0, {18'h0, e1});
    // No read command follows the DLL enable on the link
    $display("test program done");
    u_ctl.cmd(1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 3'h0, 14'h0);
    repeat (8) @(posedge clock);
    `CHK("mask", 8'h01, refresh_bank_mask)
    `CHK("dll", 1'b0, dll_active)
    rd(3'h3, st(5'h01) ^ 32'h60);
    u_ctl.cmd(1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 3'h0, 14'h0);
    repeat (8) @(posedge clock);
    `CHK("mask", 8'hff, refresh_bank_mask)
    `CHK("dll", 1'b1, dll_active)
    $display("test self refresh done");
    for (int k = 1; k <= 2; k++) begin
      lk(3'h1, e1 | (14'(k) << 7));
      `CHK("dq_oe", 3'b111, {dq_oe, dqs_oe, dqs_n_oe})
      `CHK("dq_out", {DQ_W{k == 1}}, dq_out)
      `CHK("dqs", {k == 1, k != 1}, {dqs_out, dqs_n_out})
      rd(3'h3, st(5'(k << 1)));
      lk(3'h1, e1);
      `CHK("dq_oe", 1'b0, dq_oe)
    end
    lk(3'h1, e1 | 14'h0480);
    `CHK("dqs_oe", 2'b10, {dqs_oe, dqs_n_oe})
    lk(3'h1, e1);
    lk(3'h1, e1 | 14'h1080);
    `CHK("oe", 3'b000, {dq_oe, dqs_oe, dqs_n_oe})
    lk(3'h1, e1);
    $display("test drive done");
    for (int c = 0; c < 16; c++) adj(4'(c));
    repeat (17) adj(4'h5);
    repeat (17) adj(4'ha);
    lk(3'h1, e1);
    rd(3'h3, st(5'h01));
    lk(3'h1, e1 | 14'h0380);
    pu = 4'h8;
    pd = 4'h8;
    lk(3'h1, e1);
    rd(3'h3, st(5'h01));
    `CHK("steps", 8'h88, {pulldown_step, pullup_step})
    $display("test adjust done");
    results();
  end
endmodule // emr_core_bench

bind emr_core emr_core_chk #(.DQ_W(DQ_W), .SW(SW)) u_chk (.clock, .rst, .avs_read, .avs_write,
  .avs_waitrequest, .dq_out, .dq_oe, .dqs_out, .dqs_oe, .dqs_n_out, .dqs_n_oe,
  .refresh_bank_mask, .pullup_step, .pulldown_step);
